// >>> core/brownout_reset_sequencer_params.svh
// constants for the brown-out reset sequencer
//
// How it works
// - after power-on, hold execution for regulator start-up of about 20 us
// - reapply the regulator start-up hold after every power-down, not only first
// - brown-out is the core supply node compared below an internal reference
// - a detected brown-out produces a reset pulse that resets the whole device
// - brown-out reset picks clock source from initial select only; primary mode decides the start-up timer
// - with an oscillator mode, run start-up timer and hold clock until expiry
// - with PLL in use, hold clock until the PLL settled flag is one
// - apply power-up timer delay in parallel with the clock hold
// - zero power-up delay with crystal uses fail-safe delay of 100 instead
// - brown-out reset sets bit 1 of the reset cause register
// - monitoring stays active in sleep and idle and still resets
`ifndef BROWNOUT_RESET_SEQUENCER_PARAMS_SVH
`define BROWNOUT_RESET_SEQUENCER_PARAMS_SVH

// ******************************************************
// register offsets
// ******************************************************
`define BRS_OFF_CAUSE 12'h000
`define BRS_OFF_CTRL 12'h004
`define BRS_OFF_IRQ_STAT 12'h008
`define BRS_OFF_IRQ_MASK 12'h00c
`define BRS_OFF_STATE 12'h010

// ******************************************************
// field positions and reset values
// ******************************************************
`define BRS_CAUSE_POR_BIT 0
`define BRS_CAUSE_BROWNOUT_BIT 1
`define BRS_IRQ_BROWNOUT_BIT 0
`define BRS_IRQ_REL_BIT 1
`define BRS_CTRL_RESET 32'h0000_0000
`define BRS_MASK_RESET 2'h0

// ******************************************************
// timing
// ******************************************************
`define BRS_CLK_MHZ 40
`define BRS_STARTUP_US 20
`define BRS_STARTUP_CYC (`BRS_STARTUP_US * `BRS_CLK_MHZ)
`define BRS_FAILSAFE_US 100
`define BRS_FAILSAFE_CYC (`BRS_FAILSAFE_US * `BRS_CLK_MHZ)
`define BRS_RSTPULSE_CYC 4
`define BRS_OSC_TIMER_CYC 1024
`define BRS_PWRUP_CYC 2560

`endif

// >>> core/brownout_reset_sequencer_pkg.sv
// types of the brown-out reset sequencer
package brownout_reset_sequencer_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_PULSE,
    ST_HOLD,
    ST_DONE_WAIT
  } seq_state_type;
endpackage

// >>> core/brownout_reset_sequencer.sv
// brown-out reset sequencer with apb register access
`timescale 1ns/1ps
`include "brownout_reset_sequencer_params.svh"
module brownout_reset_sequencer #(
  parameter int unsigned STARTUP_CYC = `BRS_STARTUP_CYC,
  parameter int unsigned FAILSAFE_CYC = `BRS_FAILSAFE_CYC,
  parameter int unsigned OSC_TIMER_CYC = `BRS_OSC_TIMER_CYC,
  parameter int unsigned PWRUP_CYC = `BRS_PWRUP_CYC,
  parameter int unsigned CNT_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_core_supply_low,
  input wire logic i_power_down,
  input wire logic [2:0] i_initial_osc_select,
  input wire logic [1:0] i_primary_osc_mode,
  input wire logic i_pll_settled,
  input wire logic i_low_power_mode,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_device_reset,
  output logic o_clock_hold,
  output logic o_exec_enable,
  output logic [2:0] o_clock_source,
  output logic o_irq
);
  if (STARTUP_CYC < 1 || FAILSAFE_CYC < 1 || OSC_TIMER_CYC < 1 ||
      PWRUP_CYC < 1) begin : g_bad_count
    $error("timing counts must be at least one");
  end
  if (CNT_W < 2 || CNT_W > 31 || STARTUP_CYC >= (1 << CNT_W) ||
      FAILSAFE_CYC >= (1 << CNT_W) || OSC_TIMER_CYC >= (1 << CNT_W) ||
      PWRUP_CYC >= (1 << CNT_W)) begin : g_bad_width
    $error("counter width too small");
  end

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_low_power_mode, i_pll_settled, i_power_down,
                  i_core_supply_low};
      sync2_q <= sync1_q;
    end
  end
  // comparator output: supply node below the internal reference
  wire brown_low = sync2_q[0];
  wire pwr_down = sync2_q[1];
  wire pll_ok = sync2_q[2];
  // straps are not reset so they have settled by the last counter load
  // at the end of reset
  logic [4:0] strap1_q;
  logic [4:0] strap2_q;
  always_ff @(posedge i_sys_clk) begin
    strap1_q <= {i_initial_osc_select, i_primary_osc_mode};
    strap2_q <= strap1_q;
  end

  // ******************************************************
  // control register
  // ******************************************************
  // ctrl: [0] powerup timer enabled, [1] crystal in use, [2] pll in use
  logic [2:0] ctrl_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_stat_q;
  logic [1:0] cause_q;
  wire wr_access = i_psel & i_penable & i_pwrite;
  wire rd_access = i_psel & i_penable & ~i_pwrite;
  wire cause_wr = wr_access && i_paddr == `BRS_OFF_CAUSE;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_q <= 3'(`BRS_CTRL_RESET);
      irq_mask_q <= `BRS_MASK_RESET;
    end else if (wr_access) begin
      if (i_paddr == `BRS_OFF_CTRL)
        ctrl_q <= i_pwdata[2:0];
      if (i_paddr == `BRS_OFF_IRQ_MASK)
        irq_mask_q <= i_pwdata[1:0];
    end
  end
  wire powerup_timer_en = ctrl_q[0];
  wire crystal = ctrl_q[1];
  wire pll_use = ctrl_q[2];

  // ******************************************************
  // sequencer
  // ******************************************************
  brownout_reset_sequencer_pkg::seq_state_type state_q;
  logic [CNT_W-1:0] reg_cnt_q;
  logic [CNT_W-1:0] osc_timer_cnt_q;
  logic [CNT_W-1:0] pwr_cnt_q;
  logic [2:0] pulse_cnt_q;
  logic from_brownout_q;
  logic osc_mode_q;
  wire reg_done = reg_cnt_q == '0;
  wire osc_timer_done = ~osc_mode_q | osc_timer_cnt_q == '0;
  wire clk_done = osc_timer_done & (~pll_use | pll_ok);
  wire pwr_done = pwr_cnt_q == '0;
  wire all_done = reg_done & clk_done & pwr_done;
  // monitoring ignores sleep and idle: low power never masks the trigger
  wire trigger = brown_low | pwr_down;
  logic released;
  assign released = state_q == brownout_reset_sequencer_pkg::ST_RUN;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= brownout_reset_sequencer_pkg::ST_HOLD;
      pulse_cnt_q <= 3'h0;
      from_brownout_q <= 1'b0;
    end else if (trigger) begin
      state_q <= brownout_reset_sequencer_pkg::ST_PULSE;
      pulse_cnt_q <= 3'(`BRS_RSTPULSE_CYC - 1);
      from_brownout_q <= brown_low;
    end else begin
      // the sag is over: the next one is a new episode and flags again
      from_brownout_q <= 1'b0;
      unique case (state_q)
        brownout_reset_sequencer_pkg::ST_RUN: ;
        brownout_reset_sequencer_pkg::ST_PULSE: begin
          if (pulse_cnt_q == 3'h0)
            state_q <= brownout_reset_sequencer_pkg::ST_HOLD;
          else
            pulse_cnt_q <= pulse_cnt_q - 3'h1;
        end
        brownout_reset_sequencer_pkg::ST_HOLD: begin
          if (all_done)
            state_q <= brownout_reset_sequencer_pkg::ST_DONE_WAIT;
        end
        brownout_reset_sequencer_pkg::ST_DONE_WAIT:
          state_q <= brownout_reset_sequencer_pkg::ST_RUN;
        default: state_q <= brownout_reset_sequencer_pkg::ST_HOLD;
      endcase
    end
  end

  // hold-off counters reload while the reset pulse is active
  wire loading = i_rst | trigger |
                 state_q == brownout_reset_sequencer_pkg::ST_PULSE;
  always_ff @(posedge i_sys_clk) begin
    if (loading) begin
      reg_cnt_q <= CNT_W'(STARTUP_CYC);
    end else if (!reg_done) begin
      reg_cnt_q <= reg_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (loading) begin
      // primary oscillator modes other than 2'b11 count as oscillator
      osc_mode_q <= strap2_q[1:0] != 2'h3;
      osc_timer_cnt_q <= CNT_W'(OSC_TIMER_CYC);
    end else if (!osc_timer_done) begin
      osc_timer_cnt_q <= osc_timer_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (loading) begin
      if (powerup_timer_en)
        pwr_cnt_q <= CNT_W'(PWRUP_CYC);
      else if (crystal)
        pwr_cnt_q <= CNT_W'(FAILSAFE_CYC);
      else
        pwr_cnt_q <= '0;
    end else if (!pwr_done) begin
      pwr_cnt_q <= pwr_cnt_q - 1'b1;
    end
  end

  // ******************************************************
  // cause and interrupt flags
  // ******************************************************
  wire brownout_event = brown_low & ~from_brownout_q &
                   state_q != brownout_reset_sequencer_pkg::ST_PULSE;
  wire rel_event = state_q == brownout_reset_sequencer_pkg::ST_DONE_WAIT;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cause_q <= 2'h1;
    end else begin
      if (cause_wr)
        cause_q <= cause_q & ~i_pwdata[1:0];
      if (brownout_event)
        cause_q[`BRS_CAUSE_BROWNOUT_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (wr_access && i_paddr == `BRS_OFF_IRQ_STAT)
        irq_stat_q <= irq_stat_q & ~i_pwdata[1:0];
      if (brownout_event)
        irq_stat_q[`BRS_IRQ_BROWNOUT_BIT] <= 1'b1;
      if (rel_event)
        irq_stat_q[`BRS_IRQ_REL_BIT] <= 1'b1;
    end
  end

  // ******************************************************
  // apb read and outputs
  // ******************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
      if (i_psel & ~i_penable) begin
        unique case (i_paddr)
          `BRS_OFF_CAUSE: o_prdata <= {30'h0, cause_q};
          `BRS_OFF_CTRL: o_prdata <= {29'h0, ctrl_q};
          `BRS_OFF_IRQ_STAT: o_prdata <= {30'h0, irq_stat_q};
          `BRS_OFF_IRQ_MASK: o_prdata <= {30'h0, irq_mask_q};
          `BRS_OFF_STATE: o_prdata <= {27'h0, pll_ok, all_done,
                                       o_clock_hold, o_device_reset,
                                       o_exec_enable};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_device_reset <= 1'b1;
      o_clock_hold <= 1'b1;
      o_exec_enable <= 1'b0;
      o_clock_source <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      o_device_reset <= ~released | trigger;
      o_clock_hold <= trigger | loading | ~clk_done;
      o_exec_enable <= released & ~trigger & reg_done;
      if (loading)
        o_clock_source <= strap2_q[4:2];
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  property p_release_needs_all;
    @(posedge i_sys_clk) disable iff (i_rst)
      $fell(o_device_reset) |-> $past(all_done, 2);
  endproperty
  a_release_needs_all: assert property (p_release_needs_all)
    else $error("reset released before hold-offs done");

  property p_trigger_resets;
    @(posedge i_sys_clk) disable iff (i_rst)
      trigger |=> o_device_reset;
  endproperty
  a_trigger_resets: assert property (p_trigger_resets)
    else $error("trigger did not assert reset");

  property p_brownout_flag;
    @(posedge i_sys_clk) disable iff (i_rst)
      brownout_event |=> cause_q[`BRS_CAUSE_BROWNOUT_BIT];
  endproperty
  a_brownout_flag: assert property (p_brownout_flag)
    else $error("brown-out flag not set");

  property p_pll_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      (pll_use && !pll_ok && !loading) |=> o_clock_hold;
  endproperty
  a_pll_hold: assert property (p_pll_hold)
    else $error("clock released without pll settled");

  property p_exec_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      !reg_done |=> !o_exec_enable;
  endproperty
  a_exec_hold: assert property (p_exec_hold)
    else $error("execution enabled during regulator start-up");

  property p_reload;
    @(posedge i_sys_clk) disable iff (i_rst)
      pwr_down |=> ##1 reg_cnt_q == CNT_W'(STARTUP_CYC);
  endproperty
  a_reload: assert property (p_reload)
    else $error("start-up interval not reapplied");

  property p_sleep_reset;
    @(posedge i_sys_clk) disable iff (i_rst)
      (sync2_q[3] && brown_low) |=> o_device_reset;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset)
    else $error("no reset in low power mode");

  property p_pwr_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      !pwr_done |=> o_device_reset;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold)
    else $error("reset released during power-up delay");
endmodule

// >>> tb/supply_osc_model.sv
// model of the analog supply monitor and the pll facing the sequencer
`timescale 1ns/1ps
module supply_osc_model #(
  parameter int PLL_LAG = 60
) (
  input wire logic i_sys_clk,
  input wire logic i_sag,
  input wire logic i_device_reset,
  output logic o_core_supply_low,
  output logic o_pll_settled
);
  int lag_q = 0;
  logic rst_q = 1'b0;
  // ******************************************************
  // comparator and pll lock
  // ******************************************************
  // the core supply node sits below the reference while it sags
  assign o_core_supply_low = i_sag;
  // lock is lost each time the device reset restarts the clock, so a
  // slow pll really stretches the hold instead of being settled already
  always @(posedge i_sys_clk) begin
    rst_q <= i_device_reset;
    if (i_device_reset && !rst_q) begin
      lag_q <= 0;
    end else if (lag_q < PLL_LAG) begin
      lag_q <= lag_q + 1;
    end
  end
  assign o_pll_settled = (lag_q >= PLL_LAG);
endmodule

// >>> tb/brownout_reset_sequencer_bench.sv
// self-checking bench for the brown-out reset sequencer
`timescale 1ns/1ps
module brownout_reset_sequencer_bench;
  localparam int STC = 8, FSC = 40, OSC = 12, PUC = 16, PLC = 60;
  logic clk = 1'b0, rst = 1'b1, pdn = 1'b0, sag = 1'b0, lpm = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, low, pll, rdy, err_o;
  logic [1:0] mode = 2'h3;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdat = 32'h0, prd, rd;
  logic dev_rst, hold, exe, irq, e, ia;
  logic [2:0] src;
  logic [2:0] osel = 3'h1;
  int fails = 0, total_checks = 0, cyc = 0;
  int ctls[7] = '{0, 0, 1, 2, 3, 4, 0};
  int mds[7] = '{3, 0, 3, 3, 3, 3, 3};
  int pds[7] = '{0, 0, 0, 0, 0, 0, 1};
  int los[7] = '{STC, OSC, PUC, FSC, PUC, PLC, STC};
  brownout_reset_sequencer #(.STARTUP_CYC(STC), .FAILSAFE_CYC(FSC),
    .OSC_TIMER_CYC(OSC), .PWRUP_CYC(PUC)) brownout_reset_sequencer_i (
    .i_sys_clk(clk), .i_rst(rst), .i_core_supply_low(low),
    .i_power_down(pdn), .i_initial_osc_select(osel),
    .i_primary_osc_mode(mode), .i_pll_settled(pll),
    .i_low_power_mode(lpm), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err_o), .o_device_reset(dev_rst),
    .o_clock_hold(hold), .o_exec_enable(exe), .o_clock_source(src),
    .o_irq(irq));
  supply_osc_model #(.PLL_LAG(PLC)) supply_osc_model_i (
    .i_sys_clk(clk), .i_sag(sag), .i_device_reset(dev_rst),
    .o_core_supply_low(low), .o_pll_settled(pll));
  // ******************************************************
  // clock, timeout and shared tasks
  // ******************************************************
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // the answer is taken at the rising edge that sees pready high; status
  // pins are looked at on the falling edge, where they have settled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd = prd;
    e = err_o;
    psel <= 1'b0;
    pen <= 1'b0;
    check(n < 50, 1);
  endtask
  task automatic episode(input int ctl, input int md, input int pd,
                         input int lo);
    int n;
    n = 0;
    apb(1'b1, 12'h004, ctl);
    @(posedge clk);
    mode <= md[1:0];
    lpm <= ~lpm;
    pdn <= pd[0];
    sag <= ~pd[0];
    osel <= ctl[2:0] + 3'h1;
    while (dev_rst !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check({hold, exe, n < 20}, 3'h5);
    @(posedge clk);
    sag <= 1'b0;
    pdn <= 1'b0;
    n = 0;
    while (dev_rst !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(n >= lo, 1);
    check(n <= lo + 20, 1);
    check(exe, 1);
    check(src, {29'h0, ctl[2:0] + 3'h1});
  endtask
  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h010, 0);
    check(rd & 7, 2);
    apb(1'b0, 12'h000, 0);
    check(rd & 1, 1);
    while (dev_rst !== 1'b0) begin
      @(negedge clk);
    end
    check(exe, 1);
    for (int i = 0; i < 7; i++) begin
      episode(ctls[i], mds[i], pds[i], los[i]);
    end
    apb(1'b0, 12'h000, 0);
    check(rd & 2, 2);
    apb(1'b1, 12'h000, 2);
    apb(1'b0, 12'h000, 0);
    check(rd & 2, 0);
    // two sags in a row must each raise the cause flag again
    for (int i = 0; i < 2; i++) begin
      episode(0, 3, 0, STC);
      apb(1'b0, 12'h000, 0);
      check(rd & 2, 2);
      apb(1'b1, 12'h000, 2);
    end
    apb(1'b1, 12'h00c, 0);
    apb(1'b0, 12'h008, 0);
    check(rd & 1, 1);
    ia = irq;
    apb(1'b1, 12'h00c, 3);
    apb(1'b0, 12'h00c, 0);
    check(ia ^ irq, 1);
    apb(1'b1, 12'h00c, 0);
    apb(1'b1, 12'h008, 3);
    apb(1'b0, 12'h008, 0);
    check({rd[1:0], irq}, 0);
    apb(1'b0, 12'h100, 0);
    check(e, 1);
    print_verdict();
  end
endmodule
